// *** hdl/asc_regs.vh ***
// Purpose: timing constants for the async static memory controller
// Assumes: times in ns, clock period in ns
// Notes: cycle counts derived with round-up for minimum times
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
`define ASC_CLK_PERIOD_NS 100
// read cycle and access times
`define ASC_T_READ_CYCLE_NS 55
`define ASC_T_ADDR_ACCESS_NS 55
`define ASC_T_OE_ACCESS_NS 30
`define ASC_T_OE_HIGHZ_NS 20
// write cycle times
`define ASC_T_WRITE_CYCLE_NS 55
`define ASC_T_WRITE_PULSE_NS 45
`define ASC_T_DATA_SETUP_NS 25
`define ASC_T_WRITE_TURNOFF_NS 20
`define ASC_T_OUT_FROM_WRITE_NS 5
// retention recovery equals one read cycle
`define ASC_T_RETENTION_RECOVERY_NS 55
// cycle counts
`define ASC_CYC(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_READ_CYC `ASC_CYC(`ASC_T_ADDR_ACCESS_NS)
`define ASC_WPULSE_CYC `ASC_CYC(`ASC_T_WRITE_PULSE_NS + `ASC_T_WRITE_TURNOFF_NS + `ASC_T_DATA_SETUP_NS)
`define ASC_TURN_CYC `ASC_CYC(`ASC_T_OE_HIGHZ_NS)
`define ASC_RECOV_CYC `ASC_CYC(`ASC_T_RETENTION_RECOVERY_NS)
`endif

// *** hdl/asc_sync2.v ***
// Purpose: two-stage synchroniser for pin inputs
// Assumes: single clock ref_clk
// Notes: first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module asc_sync2 #(
  parameter W = 16
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] stage1;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      stage1 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule
`default_nettype wire

// *** hdl/asc_ctrl.v ***
// Purpose: host controller for an async 1M x 16 static memory
// Assumes: 10 MHz ref_clk; memory has no clock or reset
// Notes: one access at a time; req taken when ready is high
//   read data crosses two resync flops, so sampling runs late
//
// Behaviour
// - sample read data after address access time
// - write strobe high, read cycle minimum length
// - address changes only while strobes inactive
// - write cycle and address valid minimums
// - select, strobe, byte enable minimum widths
// - write data setup before end, zero hold
// - strobe exceeds turnoff plus data setup
// - no bus drive while memory still drives
// - hold deselected during low supply retention
// - deselect before supply drop, wait after
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.vh"
module asc_ctrl #(
  parameter AW = 20,
  parameter DW = 16,
  parameter [7:0] READ_CYC = `ASC_READ_CYC,
  parameter [7:0] WPULSE_CYC = `ASC_WPULSE_CYC,
  parameter [7:0] TURN_CYC = `ASC_TURN_CYC,
  parameter [7:0] RECOV_CYC = `ASC_RECOV_CYC
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // user request
  input wire req,
  input wire req_write,
  input wire [AW-1:0] req_addr,
  input wire [DW-1:0] req_wdata,
  input wire [1:0] req_byte_en,
  output wire ready,
  output reg rdata_valid,
  output reg [DW-1:0] rdata,
  // retention control
  input wire retain_req,
  output wire retained,
  // memory pins
  output reg [AW-1:0] word_address_pins,
  output reg select_n,
  output reg select_active_high,
  output reg write_strobe_n,
  output reg output_drive_n,
  output reg low_byte_enable_n,
  output reg upper_byte_enable_n,
  input wire [DW-1:0] shared_data_pins_in,
  output reg [DW-1:0] shared_data_pins_out,
  output reg shared_data_pins_oe
);
  ////////////////////////////////////////////////////////////////////
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_READ = 3'h1;
  localparam [2:0] ST_TURN = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_END = 3'h4;
  localparam [2:0] ST_RETAIN = 3'h5;
  localparam [2:0] ST_RECOV = 3'h6;
  // sample point: access time plus the two resync stages
  localparam [7:0] READ_END = READ_CYC + 8'h02;

  reg [2:0] state;
  reg [7:0] count;
  reg [2:0] next_state;
  wire [DW-1:0] data_sync;
  wire retain_sync;

  ////////////////////////////////////////////////////////////////////
  // pins come from another domain, so resync before use
  asc_sync2 #(.W(DW)) u_data_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din(shared_data_pins_in),
    .dout(data_sync)
  );
  asc_sync2 #(.W(1)) u_retain_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din(retain_req),
    .dout(retain_sync)
  );

  // no new work while a retention request is pending
  assign ready = (state == ST_IDLE) && !retain_sync;
  assign retained = (state == ST_RETAIN);

  ////////////////////////////////////////////////////////////////////
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (retain_sync)
          next_state = ST_RETAIN;
        else if (req && req_write)
          next_state = ST_TURN;
        else if (req)
          next_state = ST_READ;
      end
      ST_READ: begin
        // slower than needed, but read data has no handshake
        if (count == READ_END)
          next_state = ST_END;
      end
      ST_TURN: begin
        if (count == TURN_CYC)
          next_state = ST_WRITE;
      end
      ST_WRITE: begin
        if (count == WPULSE_CYC)
          next_state = ST_END;
      end
      ST_END: next_state = ST_IDLE;
      ST_RETAIN: begin
        if (!retain_sync)
          next_state = ST_RECOV;
      end
      ST_RECOV: begin
        // one read cycle of rest before the first access
        if (count == RECOV_CYC)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      count <= 8'h00;
      rdata_valid <= 1'b0;
      rdata <= {DW{1'b0}};
      word_address_pins <= {AW{1'b0}};
      // memory sees a parked, deselected bus in reset
      select_n <= 1'b1;
      select_active_high <= 1'b0;
      write_strobe_n <= 1'b1;
      output_drive_n <= 1'b1;
      low_byte_enable_n <= 1'b1;
      upper_byte_enable_n <= 1'b1;
      shared_data_pins_out <= {DW{1'b0}};
      shared_data_pins_oe <= 1'b0;
    end else begin
      state <= next_state;
      rdata_valid <= 1'b0;
      // count restarts on every state change
      if (next_state != state)
        count <= 8'h01;
      else
        count <= count + 8'h01;
      case (state)
        ST_IDLE: begin
          write_strobe_n <= 1'b1;
          if (!retain_sync && req) begin
            // address set on the same edge that the selects and enables go active
            word_address_pins <= req_addr;
            select_n <= 1'b0;
            select_active_high <= 1'b1;
            low_byte_enable_n <= ~req_byte_en[0];
            upper_byte_enable_n <= ~req_byte_en[1];
            // output enable stays high on writes: no bus fight
            output_drive_n <= req_write;
            // value set early, driven only after the turnaround
            shared_data_pins_out <= req_wdata;
          end
        end
        ST_TURN: begin
          // strobe falls with selects low; pins start driving on the same edge
          if (next_state == ST_WRITE) begin
            write_strobe_n <= 1'b0;
            shared_data_pins_oe <= 1'b1;
          end
        end
        ST_READ: begin
          if (next_state == ST_END) begin
            rdata <= data_sync;
            rdata_valid <= 1'b1;
          end
        end
        ST_WRITE: begin
          // zero hold: data and selects drop a cycle later
          if (next_state == ST_END)
            write_strobe_n <= 1'b1;
        end
        ST_END: begin
          // deselect first, address stays put, zero hold is legal
          select_n <= 1'b1;
          select_active_high <= 1'b0;
          low_byte_enable_n <= 1'b1;
          upper_byte_enable_n <= 1'b1;
          output_drive_n <= 1'b1;
          shared_data_pins_oe <= 1'b0;
        end
        ST_RETAIN: begin
          // park every strobe so nothing moves at low supply
          select_n <= 1'b1;
          select_active_high <= 1'b0;
          write_strobe_n <= 1'b1;
          output_drive_n <= 1'b1;
          low_byte_enable_n <= 1'b1;
          upper_byte_enable_n <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** tb/asc_ctrl_asserts.sv ***
// Purpose: pin timing checks
// Assumes: 10 MHz clock
// Notes: design outputs only
`timescale 1ns/100ps
`default_nettype none
module asc_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // status
  input wire logic ready,
  input wire logic rdata_valid,
  input wire logic retained,
  // memory pins
  input wire logic [19:0] word_address_pins,
  input wire logic select_n,
  input wire logic select_active_high,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic [15:0] shared_data_pins_out,
  input wire logic shared_data_pins_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire sel = !select_n && select_active_high;
  wire [15:0] dq = shared_data_pins_out;
  a_read_strobe: assert property (
    !output_drive_n |-> write_strobe_n) else $error("rd strobe");
  a_read_len: assert property (
    $fell(output_drive_n) |-> !output_drive_n [*2]) else $error("rd len");
  a_read_sample: assert property (
    rdata_valid |-> $past(sel, 2) && $past(!output_drive_n, 2))
    else $error("rd sample");
  a_addr_quiet: assert property (
    $changed(word_address_pins) |-> write_strobe_n && $past(write_strobe_n))
    else $error("addr move");
  a_write_sel: assert property (
    !write_strobe_n |-> sel && shared_data_pins_oe) else $error("wr sel");
  a_write_end: assert property (
    $rose(write_strobe_n) |-> $past(sel)) else $error("wr end");
  a_data_setup: assert property (
    $fell(write_strobe_n) |-> $stable(dq) ##1 $stable(dq))
    else $error("wr data");
  a_no_clash: assert property (
    shared_data_pins_oe |-> output_drive_n && $past(output_drive_n))
    else $error("clash");
  a_retain_off: assert property (
    retained |-> !sel) else $error("retain sel");
  a_recover_wait: assert property (
    $fell(retained) |-> !ready) else $error("recover");
  c_write: cover property ($fell(write_strobe_n));
  c_read: cover property (rdata_valid);
  c_retain: cover property ($fell(retained));
endmodule
bind asc_ctrl asc_chk u_chk (.ref_clk, .rstn, .ready, .rdata_valid,
  .retained, .word_address_pins, .select_n, .select_active_high,
  .write_strobe_n, .output_drive_n, .shared_data_pins_out,
  .shared_data_pins_oe);
`default_nettype wire

// *** tb/asc_mem.sv ***
// Purpose: async memory model
// Assumes: 16 words decoded
// Notes: no clock, no reset
`timescale 1ns/100ps
`default_nettype none
module asc_mem (
  // memory pins
  input wire logic [19:0] word_address_pins,
  input wire logic select_n,
  input wire logic select_active_high,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic low_byte_enable_n,
  input wire logic upper_byte_enable_n,
  input wire logic [15:0] shared_data_pins,
  // drive toward bus
  output logic [15:0] mem_q,
  output logic [1:0] mem_oe
);
  logic [15:0] mem [0:15];
  wire [3:0] a = word_address_pins[3:0];
  wire sel = !select_n && select_active_high;
  wire wr = sel && !write_strobe_n;
  wire rd = sel && write_strobe_n && !output_drive_n;
  // off in 5 ns, on in 10 ns: release beats drive
  assign #(10,5) mem_oe =
    {rd && !upper_byte_enable_n, rd && !low_byte_enable_n};
  assign #30 mem_q = mem[a];
  always @* begin
    if (wr && !low_byte_enable_n) begin
      mem[a][7:0] = shared_data_pins[7:0];
    end
    if (wr && !upper_byte_enable_n) begin
      mem[a][15:8] = shared_data_pins[15:8];
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_asc_ctrl.sv ***
// Purpose: bench for asc_ctrl
// Assumes: inputs on falling edge
// Notes: model decodes 16 words
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_asc_ctrl;
  logic ref_clk = 0, rstn = 0, req = 0, req_write = 0, retain_req = 0;
  logic [19:0] req_addr = 0;
  logic [15:0] req_wdata = 0, q;
  logic [1:0] req_byte_en = 0;
  int err_count = 0, checked = 0, cyc = 0;
  wire ready, rdata_valid, retained, sn, sh, wn, on, ln, un, doe;
  wire [19:0] adr;
  wire [15:0] rdata, dout, mq, dq;
  wire [1:0] moe;
  wire [15:0] flt = ~cyc[15:0]; // floating bus moves each cycle
  assign dq[7:0] = doe ? dout[7:0] : moe[0] ? mq[7:0] : flt[7:0];
  assign dq[15:8] = doe ? dout[15:8] : moe[1] ? mq[15:8] : flt[15:8];
  asc_ctrl u_dut (.ref_clk, .rstn, .req, .req_write, .req_addr,
    .req_wdata, .req_byte_en, .ready, .rdata_valid, .rdata, .retain_req,
    .retained, .word_address_pins(adr), .select_n(sn),
    .select_active_high(sh), .write_strobe_n(wn), .output_drive_n(on),
    .low_byte_enable_n(ln), .upper_byte_enable_n(un),
    .shared_data_pins_in(dq), .shared_data_pins_out(dout),
    .shared_data_pins_oe(doe));
  asc_mem u_mem (.word_address_pins(adr), .select_n(sn),
    .select_active_high(sh), .write_strobe_n(wn), .output_drive_n(on),
    .low_byte_enable_n(ln), .upper_byte_enable_n(un),
    .shared_data_pins(dq), .mem_q(mq), .mem_oe(moe));
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      err_count++;
      stop_test;
    end
  end
  task stop_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task op(input logic w, input logic [19:0] a, input logic [15:0] d,
      input logic [1:0] be);
    // no local limit: the cycle ceiling ends a hung wait
    while (ready !== 1'b1) @(negedge ref_clk);
    {req, req_write, req_addr, req_wdata, req_byte_en} = {1'b1, w, a, d, be};
    @(negedge ref_clk);
    req = 0;
    while (!w && rdata_valid !== 1'b1) @(negedge ref_clk);
    q = w ? 16'hXXXX : rdata;
  endtask
  task t_lanes;
    op(1, 20'h5, 16'h1234, 2'h3);
    op(1, 20'h5, 16'hABCD, 2'h2);
    op(0, 20'h5, 16'h0, 2'h3);
    `CHK(q, 16'hAB34)
    op(0, 20'h5, 16'h0, 2'h1);
    `CHK(q[7:0], 8'h34)
    `CHK(q[15:8] == 8'hAB, 1'b0)
    op(0, 20'h5, 16'h0, 2'h2);
    `CHK(q[15:8], 8'hAB)
    `CHK(q[7:0] == 8'h34, 1'b0)
  endtask
  task t_b2b;
    op(1, 20'h9, 16'h5A0F, 2'h3);
    op(1, 20'hA, 16'h0F5A, 2'h3);
    op(0, 20'h9, 16'h0, 2'h3);
    `CHK(q, 16'h5A0F)
    op(0, 20'hA, 16'h0, 2'h3);
    `CHK(q, 16'h0F5A)
  endtask
  task t_retain;
    retain_req = 1;
    while (retained !== 1'b1) @(negedge ref_clk);
    `CHK({sn, sh, ready}, 3'h4)
    retain_req = 0;
    while (retained !== 1'b0) @(negedge ref_clk);
    `CHK(ready, 1'b0)
    op(0, 20'h5, 16'h0, 2'h3);
    `CHK(q, 16'hAB34)
  endtask
  task t_reset;
    rstn = 0;
    repeat (4) @(negedge ref_clk);
    `CHK({sn, sh, wn, on, ln, un, doe}, 7'h5E)
    `CHK({ready, rdata_valid, retained}, 3'h4)
    rstn = 1;
    op(0, 20'h9, 16'h0, 2'h3);
    `CHK(q, 16'h5A0F)
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    rstn = 1;
    t_lanes;
    t_b2b;
    t_retain;
    t_reset;
    stop_test;
  end
endmodule
`default_nettype wire
